// *** hdl/pag_pkg.sv ***
// constants shared by the port register slave and the port logic
// assumes a 32-bit axi4-lite bus with byte addresses, 8 address bits decoded
package pag_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int PORT_W = 8;
  localparam int IDX_W  = 6;

  // ----------------------------------------------------------------
  // register indices, byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_PIN_LATCH  = 6'h00;
  localparam logic [IDX_W-1:0] IDX_DIRECTION  = 6'h04;
  localparam logic [IDX_W-1:0] IDX_PULLUP_EN  = 6'h0d;

  // ----------------------------------------------------------------
  // reset values and bus answers
  // ----------------------------------------------------------------
  localparam logic [PORT_W-1:0] RST_DIRECTION = 8'h00;
  localparam logic [PORT_W-1:0] RST_PULLUP_EN = 8'h00;
  localparam logic [PORT_W-1:0] KEYPAD_IDLE   = 8'hff;
  localparam logic [1:0]        RESP_OKAY     = 2'h0;
  localparam logic [1:0]        RESP_SLVERR   = 2'h2;
  localparam logic [1:0]        WORD_ALIGN    = 2'h0;

  // true when a byte address selects one of the three registers
  function automatic logic pag_addr_hit(input logic [ADDR_W-1:0] addr);
    logic [IDX_W-1:0] idx;
    idx = addr[ADDR_W-1:2];
    return (addr[1:0] == WORD_ALIGN) &&
           ((idx == IDX_PIN_LATCH) || (idx == IDX_DIRECTION) || (idx == IDX_PULLUP_EN));
  endfunction

endpackage : pag_pkg

// *** hdl/pag_reg_if.sv ***
// register access strobes between the bus slave and the port logic
// assumes both ends run on aclk
interface pag_reg_if;
  import pag_pkg::*;

  logic              wr_en;
  logic [IDX_W-1:0]  wr_idx;
  logic [PORT_W-1:0] wr_data;
  logic [IDX_W-1:0]  rd_idx;
  logic [PORT_W-1:0] rd_data;

  modport bus  (output wr_en, output wr_idx, output wr_data, output rd_idx, input rd_data);
  modport regs (input wr_en, input wr_idx, input wr_data, input rd_idx, output rd_data);
endinterface : pag_reg_if

// *** hdl/pag_axil_slave.sv ***
// axi4-lite slave turning bus transfers into register strobes
// assumes one clock, synchronous active-low reset, one write and one read in flight
module pag_axil_slave
  import pag_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready_r,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready_r,
  output logic [1:0]             bresp_r,
  output logic                   bvalid_r,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready_r,
  output logic [DATA_W-1:0]      rdata_r,
  output logic [1:0]             rresp_r,
  output logic                   rvalid_r,
  input  wire logic              rready,
  pag_reg_if.bus                 rif
);

  logic              aw_got_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic              w_got_r;
  logic [PORT_W-1:0] w_byte_r;
  logic              w_lane_r;
  logic              wr_fire;

  // ----------------------------------------------------------------
  // write address and data, taken in either order
  // ----------------------------------------------------------------
  assign wr_fire = aw_got_r && w_got_r && !bvalid_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b1;
      aw_got_r  <= 1'b0;
      aw_addr_r <= '0;
    end else begin
      if (awvalid && awready_r) begin
        awready_r <= 1'b0;
        aw_got_r  <= 1'b1;
        aw_addr_r <= awaddr;
      end else if (wr_fire) begin
        aw_got_r  <= 1'b0;
      end
      if (bvalid_r && bready) begin
        awready_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_r <= 1'b1;
      w_got_r  <= 1'b0;
      w_byte_r <= '0;
      w_lane_r <= 1'b0;
    end else begin
      if (wvalid && wready_r) begin
        wready_r <= 1'b0;
        w_got_r  <= 1'b1;
        w_byte_r <= wdata[PORT_W-1:0];
        w_lane_r <= wstrb[0];
      end else if (wr_fire) begin
        w_got_r  <= 1'b0;
      end
      if (bvalid_r && bready) begin
        wready_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // write response
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r  <= pag_addr_hit(aw_addr_r) ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_r && bready) begin
      bvalid_r <= 1'b0;
    end
  end

  assign rif.wr_en   = wr_fire && w_lane_r && pag_addr_hit(aw_addr_r);
  assign rif.wr_idx  = aw_addr_r[ADDR_W-1:2];
  assign rif.wr_data = w_byte_r;
  assign rif.rd_idx  = araddr[ADDR_W-1:2];

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= '0;
      rresp_r   <= RESP_OKAY;
    end else if (arvalid && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rdata_r   <= pag_addr_hit(araddr) ? {{(DATA_W-PORT_W){1'b0}}, rif.rd_data} : '0;
      rresp_r   <= pag_addr_hit(araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_r && rready) begin
      rvalid_r  <= 1'b0;
      arready_r <= 1'b1;
    end
  end

endmodule // pag_axil_slave

// *** hdl/pag_gpio_top.sv ***
// eight-bit general-purpose port with latch, direction and pullup enable
// assumes pins and keypad enables synchronous to aclk; pad resolves pullup
module pag_gpio_top
  import pag_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic [2:0]        awprot,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic [2:0]        arprot,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [DATA_W-1:0]      rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic [PORT_W-1:0] pin_in,
  output logic [PORT_W-1:0]      pin_out,
  output logic [PORT_W-1:0]      pin_oe,
  output logic [PORT_W-1:0]      pin_pullup,
  input  wire logic [PORT_W-1:0] keypad_irq_enable_bits,
  output logic [PORT_W-1:0]      keypad_inputs
);

  pag_reg_if rif ();

  logic [PORT_W-1:0] pin_latch_bits_r;
  logic [PORT_W-1:0] pin_latch_bits_nxt;
  logic [PORT_W-1:0] direction_bits_r;
  logic [PORT_W-1:0] direction_bits_nxt;
  logic [PORT_W-1:0] pullup_enable_bits_r;
  logic [PORT_W-1:0] pullup_enable_bits_nxt;
  logic [PORT_W-1:0] pullup_r;
  logic [PORT_W-1:0] keypad_r;
  logic [PORT_W-1:0] data_view;
  logic              wr_latch;
  logic              wr_dir;
  logic              wr_pue;

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  pag_axil_slave u_slave (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .awaddr    (awaddr),
    .awvalid   (awvalid),
    .awready_r (awready),
    .wdata     (wdata),
    .wstrb     (wstrb),
    .wvalid    (wvalid),
    .wready_r  (wready),
    .bresp_r   (bresp),
    .bvalid_r  (bvalid),
    .bready    (bready),
    .araddr    (araddr),
    .arvalid   (arvalid),
    .arready_r (arready),
    .rdata_r   (rdata),
    .rresp_r   (rresp),
    .rvalid_r  (rvalid),
    .rready    (rready),
    .rif       (rif.bus)
  );

  // ----------------------------------------------------------------
  // register write decode
  // ----------------------------------------------------------------
  assign wr_latch = rif.wr_en && (rif.wr_idx == IDX_PIN_LATCH);
  assign wr_dir   = rif.wr_en && (rif.wr_idx == IDX_DIRECTION);
  assign wr_pue   = rif.wr_en && (rif.wr_idx == IDX_PULLUP_EN);

  always_comb begin
    pin_latch_bits_nxt = pin_latch_bits_r;
    if (wr_latch) begin
      pin_latch_bits_nxt = rif.wr_data;
    end
  end

  always_comb begin
    direction_bits_nxt = direction_bits_r;
    if (wr_dir) begin
      direction_bits_nxt = rif.wr_data;
    end
  end

  always_comb begin
    pullup_enable_bits_nxt = pullup_enable_bits_r;
    if (wr_pue) begin
      pullup_enable_bits_nxt = rif.wr_data;
    end
  end

  // ----------------------------------------------------------------
  // data latch, never reset
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    pin_latch_bits_r <= pin_latch_bits_nxt;
  end

  // ----------------------------------------------------------------
  // direction and pullup enable
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      direction_bits_r <= RST_DIRECTION;
    end else begin
      direction_bits_r <= direction_bits_nxt;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pullup_enable_bits_r <= RST_PULLUP_EN;
    end else begin
      pullup_enable_bits_r <= pullup_enable_bits_nxt;
    end
  end

  // pullup follows next values so it never lags the direction change
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pullup_r <= RST_PULLUP_EN;
    end else begin
      pullup_r <= pullup_enable_bits_nxt & ~direction_bits_nxt;
    end
  end

  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  assign pin_out    = pin_latch_bits_r;
  assign pin_oe     = direction_bits_r;
  assign pin_pullup = pullup_r;

  // ----------------------------------------------------------------
  // keypad sharing, disabled bits idle high
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      keypad_r <= KEYPAD_IDLE;
    end else begin
      keypad_r <= (pin_in & keypad_irq_enable_bits) | ~keypad_irq_enable_bits;
    end
  end

  assign keypad_inputs = keypad_r;

  // ----------------------------------------------------------------
  // register read mux
  // ----------------------------------------------------------------
  assign data_view = (direction_bits_r & pin_latch_bits_r) | (~direction_bits_r & pin_in);

  always_comb begin
    case (rif.rd_idx)
      IDX_PIN_LATCH: rif.rd_data = data_view;
      IDX_DIRECTION: rif.rd_data = direction_bits_r;
      IDX_PULLUP_EN: rif.rd_data = pullup_enable_bits_r;
      default:       rif.rd_data = '0;
    endcase
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_latch_write;
    wr_latch ##1 1'b1;
  endsequence

  sequence s_dir_write;
    wr_dir ##1 1'b1;
  endsequence

  sequence s_pue_write;
    wr_pue ##1 1'b1;
  endsequence

  property p_latch_store;
    @(posedge aclk) disable iff (!aresetn)
      wr_latch |=> (pin_latch_bits_r == $past(rif.wr_data)) && (pin_out == $past(rif.wr_data));
  endproperty
  a_latch_store: assert property (p_latch_store) else $error("latch missed write");

  property p_latch_hold_reset;
    @(posedge aclk) $rose(aresetn) |-> pin_latch_bits_r === $past(pin_latch_bits_r, 2);
  endproperty
  a_latch_hold_reset: assert property (p_latch_hold_reset) else $error("reset hit latch");

  property p_oe_follows_dir;
    @(posedge aclk) disable iff (!aresetn)
      s_dir_write |-> pin_oe == $past(rif.wr_data);
  endproperty
  a_oe_follows_dir: assert property (p_oe_follows_dir) else $error("driver not per direction");

  property p_dir_reset;
    @(posedge aclk) $rose(aresetn) |-> (pin_oe == 8'h00) && (pin_pullup == 8'h00);
  endproperty
  a_dir_reset: assert property (p_dir_reset) else $error("direction not cleared");

  property p_read_view;
    @(posedge aclk) disable iff (!aresetn)
      (rif.rd_idx == IDX_PIN_LATCH) |->
        rif.rd_data == ((pin_oe & pin_out) | (~pin_oe & pin_in));
  endproperty
  a_read_view: assert property (p_read_view) else $error("data read mux wrong");

  property p_input_write;
    @(posedge aclk) disable iff (!aresetn)
      (wr_latch && !wr_dir && direction_bits_r == 8'h00) |=>
        (pin_oe == 8'h00) && (data_view == pin_in);
  endproperty
  a_input_write: assert property (p_input_write) else $error("input write changed view");

  property p_pullup_gate;
    @(posedge aclk) disable iff (!aresetn)
      ##1 pin_pullup == (pullup_enable_bits_r & ~direction_bits_r);
  endproperty
  a_pullup_gate: assert property (p_pullup_gate) else $error("pullup gating wrong");

  property p_dir_readback;
    @(posedge aclk) disable iff (!aresetn)
      s_latch_write or s_dir_write |->
        (rif.rd_idx != IDX_DIRECTION) || (rif.rd_data == direction_bits_r);
  endproperty
  a_dir_readback: assert property (p_dir_readback) else $error("direction readback wrong");

  property p_keypad_map;
    @(posedge aclk) disable iff (!aresetn)
      $past(aresetn) |->
        keypad_inputs == (($past(pin_in) & $past(keypad_irq_enable_bits))
                          | ~$past(keypad_irq_enable_bits));
  endproperty
  a_keypad_map: assert property (p_keypad_map) else $error("keypad mapping wrong");

  // ----------------------------------------------------------------
  // register store, hold and readback, pullup gating and keypad mapping
  // ----------------------------------------------------------------
  property p_dir_store;
    @(posedge aclk) disable iff (!aresetn)
      s_dir_write |-> direction_bits_r == $past(rif.wr_data);
  endproperty
  a_dir_store: assert property (p_dir_store) else $error("dir write lost");

  property p_pue_store;
    @(posedge aclk) disable iff (!aresetn)
      s_pue_write |-> pullup_enable_bits_r == $past(rif.wr_data);
  endproperty
  a_pue_store: assert property (p_pue_store) else $error("pue write lost");

  property p_latch_keep;
    @(posedge aclk) disable iff (!aresetn)
      !wr_latch |=> pin_latch_bits_r === $past(pin_latch_bits_r);
  endproperty
  a_latch_keep: assert property (p_latch_keep) else $error("latch changed");

  property p_dir_keep;
    @(posedge aclk) disable iff (!aresetn)
      !wr_dir |=> $stable(direction_bits_r);
  endproperty
  a_dir_keep: assert property (p_dir_keep) else $error("dir changed");

  property p_pue_keep;
    @(posedge aclk) disable iff (!aresetn)
      !wr_pue |=> $stable(pullup_enable_bits_r);
  endproperty
  a_pue_keep: assert property (p_pue_keep) else $error("pue changed");

  property p_pull_out;
    @(posedge aclk) disable iff (!aresetn)
      (pin_pullup & pin_oe) == 8'h00;
  endproperty
  a_pull_out: assert property (p_pull_out) else $error("pullup on output");

  property p_pull_back;
    @(posedge aclk) disable iff (!aresetn)
      wr_dir |=> pin_pullup == (pullup_enable_bits_r & ~$past(rif.wr_data));
  endproperty
  a_pull_back: assert property (p_pull_back) else $error("pullup lags dir");

  property p_rd_dir;
    @(posedge aclk) disable iff (!aresetn)
      (rif.rd_idx == IDX_DIRECTION) |-> rif.rd_data == direction_bits_r;
  endproperty
  a_rd_dir: assert property (p_rd_dir) else $error("dir read wrong");

  property p_rd_pue;
    @(posedge aclk) disable iff (!aresetn)
      (rif.rd_idx == IDX_PULLUP_EN) |-> rif.rd_data == pullup_enable_bits_r;
  endproperty
  a_rd_pue: assert property (p_rd_pue) else $error("pue read wrong");

  property p_rd_gap;
    @(posedge aclk) disable iff (!aresetn)
      (rif.rd_idx != IDX_PIN_LATCH) && (rif.rd_idx != IDX_DIRECTION) &&
        (rif.rd_idx != IDX_PULLUP_EN) |-> rif.rd_data == 8'h00;
  endproperty
  a_rd_gap: assert property (p_rd_gap) else $error("unmapped read not zero");

  property p_kp_idle;
    @(posedge aclk) disable iff (!aresetn)
      $past(aresetn) |-> (keypad_inputs | $past(keypad_irq_enable_bits)) == KEYPAD_IDLE;
  endproperty
  a_kp_idle: assert property (p_kp_idle) else $error("disabled keypad bit low");

  property p_kp_follow;
    @(posedge aclk) disable iff (!aresetn)
      $past(aresetn) |-> (keypad_inputs & $past(keypad_irq_enable_bits)) ==
        ($past(pin_in) & $past(keypad_irq_enable_bits));
  endproperty
  a_kp_follow: assert property (p_kp_follow) else $error("keypad bit not pin");

  property p_wr_target;
    @(posedge aclk) disable iff (!aresetn)
      rif.wr_en |-> wr_latch || wr_dir || wr_pue;
  endproperty
  a_wr_target: assert property (p_wr_target) else $error("write to no register");

  property p_in_view;
    @(posedge aclk) disable iff (!aresetn)
      (rif.rd_idx == IDX_PIN_LATCH) |-> (rif.rd_data & ~pin_oe) == (pin_in & ~pin_oe);
  endproperty
  a_in_view: assert property (p_in_view) else $error("input bits not pin");

  property p_out_view;
    @(posedge aclk) disable iff (!aresetn)
      (rif.rd_idx == IDX_PIN_LATCH) |->
        (rif.rd_data & pin_oe) == (pin_latch_bits_r & pin_oe);
  endproperty
  a_out_view: assert property (p_out_view) else $error("output bits not latch");

endmodule // pag_gpio_top

// *** tb/pag_pad_model.sv ***
// pad model: resolves each port pin from driver, outside source, pullup
// assumes the outside source is driven by the bench on aclk edges
module pag_pad_model
  import pag_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic [PORT_W-1:0] pin_out,
  input  wire logic [PORT_W-1:0] pin_oe,
  input  wire logic [PORT_W-1:0] pin_pullup,
  input  wire logic [PORT_W-1:0] ext_val,
  input  wire logic [PORT_W-1:0] ext_en,
  output logic [PORT_W-1:0]      pin_in
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [PORT_W-1:0] float_r = 8'h55;

  // undriven lines change every cycle
  always @(posedge aclk) begin
    float_r <= ~float_r;
  end

  // outside source wins, models an overdriven pin
  always_comb begin
    for (int i = 0; i < PORT_W; i++) begin
      if (ext_en[i]) pin_in[i] = ext_val[i];
      else if (pin_oe[i]) pin_in[i] = pin_out[i];
      else if (pin_pullup[i]) pin_in[i] = 1'b1;
      else pin_in[i] = float_r[i];
    end
  end
endmodule // pag_pad_model

// *** tb/port_a_gpio_with_pullups_tb.sv ***
// bench: axi4-lite register tests of the port with a pad model
// assumes the design package and the pad model are compiled first
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, (g), (e)); end end
module port_a_gpio_with_pullups_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pag_pkg::*;

  localparam logic [ADDR_W-1:0] A_LAT = {IDX_PIN_LATCH, 2'h0};
  localparam logic [ADDR_W-1:0] A_DIR = {IDX_DIRECTION, 2'h0};
  localparam logic [ADDR_W-1:0] A_PUE = {IDX_PULLUP_EN, 2'h0};

  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [DATA_W-1:0] wdata = '0, rdata;
  logic [3:0]        wstrb = '0;
  logic [1:0]        bresp, rresp;
  logic [PORT_W-1:0] pin_in, pin_out, pin_oe, pin_pullup, kp_in;
  logic [PORT_W-1:0] kp_en = '0, ext_val = '0, ext_en = '0;
  int error_cnt = 0;
  int comparisons = 0;

  pag_gpio_top uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup(pin_pullup), .keypad_irq_enable_bits(kp_en), .keypad_inputs(kp_in));

  pag_pad_model pad (.aclk(aclk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup(pin_pullup), .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));

  initial begin
    forever #4 aclk = ~aclk;
  end

  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    logic awp, wp;
    awp = 1;
    wp = 1;
    awaddr <= a; wdata <= {24'h0, d}; wstrb <= s;
    awvalid <= 1; wvalid <= 1; bready <= 1;
    while (awp || wp) begin
      @(posedge aclk);
      if (awp && awready === 1'b1) begin awvalid <= 0; awp = 0; end
      if (wp && wready === 1'b1) begin wvalid <= 0; wp = 0; end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    `CHK(bresp, er)
    bready <= 0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
    araddr <= a; arvalid <= 1; rready <= 1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    `CHK(rdata, {24'h0, ed}) `CHK(rresp, er)
    rready <= 0;
    @(posedge aclk);
  endtask

  task automatic done(input string n);
    $display("test %s done, errors %0d", n, error_cnt);
  endtask

  task automatic finish_test();
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    #(8 * 20000);
    error_cnt++;
    finish_test();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    `CHK(pin_oe, RST_DIRECTION)
    `CHK(kp_in, KEYPAD_IDLE)
    rd(A_DIR, RST_DIRECTION, RESP_OKAY);
    rd(A_PUE, RST_PULLUP_EN, RESP_OKAY);
    rd(8'h08, 8'h00, RESP_SLVERR);
    rd(8'h01, 8'h00, RESP_SLVERR);
    wr(8'h3c, 8'hff, 4'h1, RESP_SLVERR);
    done("reset_map");
    ext_en <= 8'hff; ext_val <= 8'h5a;
    @(posedge aclk);
    rd(A_LAT, 8'h5a, RESP_OKAY);
    wr(A_LAT, 8'h3c, 4'h1, RESP_OKAY);
    rd(A_LAT, 8'h5a, RESP_OKAY);
    ext_en <= 8'h0f;
    wr(A_DIR, 8'hf0, 4'h1, RESP_OKAY);
    `CHK(pin_oe, 8'hf0)
    `CHK(pin_out, 8'h3c)
    rd(A_LAT, 8'h3a, RESP_OKAY);
    rd(A_DIR, 8'hf0, RESP_OKAY);
    wr(A_LAT, 8'h00, 4'h0, RESP_OKAY);
    `CHK(pin_out, 8'h3c)
    done("direction");
    ext_en <= 8'h00;
    wr(A_PUE, 8'hff, 4'h1, RESP_OKAY);
    `CHK(pin_pullup, 8'h0f)
    rd(A_LAT, 8'h3f, RESP_OKAY);
    rd(A_PUE, 8'hff, RESP_OKAY);
    wr(A_DIR, 8'h00, 4'h1, RESP_OKAY);
    `CHK(pin_pullup, 8'hff)
    rd(A_LAT, 8'hff, RESP_OKAY);
    wr(A_PUE, 8'h00, 4'h1, RESP_OKAY);
    `CHK(pin_pullup, 8'h00)
    done("pullup");
    ext_en <= 8'hff; ext_val <= 8'ha5; kp_en <= 8'h0f;
    repeat (3) @(posedge aclk);
    `CHK(kp_in, 8'hf5)
    ext_val <= 8'h5a; kp_en <= 8'hf0;
    repeat (3) @(posedge aclk);
    `CHK(kp_in, 8'h5f)
    done("keypad");
    ext_en <= 8'h00;
    wr(A_PUE, 8'h0f, 4'h1, RESP_OKAY);
    wr(A_DIR, 8'hff, 4'h1, RESP_OKAY);
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    `CHK(pin_oe, RST_DIRECTION)
    `CHK(pin_pullup, RST_PULLUP_EN)
    `CHK(pin_out, 8'h3c)
    rd(A_PUE, RST_PULLUP_EN, RESP_OKAY);
    wr(A_DIR, 8'hff, 4'h1, RESP_OKAY);
    rd(A_LAT, 8'h3c, RESP_OKAY);
    ext_en <= 8'hff; ext_val <= 8'h00;
    @(posedge aclk);
    rd(A_LAT, 8'h3c, RESP_OKAY);
    done("mid_reset");
    finish_test();
  end
endmodule // port_a_gpio_with_pullups_tb
